/* design/rgb_panel_consts.vh */
`ifndef RGB_PANEL_CONSTS_VH
`define RGB_PANEL_CONSTS_VH

// ==================================================
// Clock figures, in ns
`define REF_CLK_PERIOD_NS    10
`define DOT_CLK_PERIOD_NS    80
// Reference cycles per dot clock, and the phases that mark its edges
`define DOT_DIV              (`DOT_CLK_PERIOD_NS / `REF_CLK_PERIOD_NS)
`define DOT_HIGH_PHASES      3'h4
`define DOT_UPDATE_PHASE     3'h3

// ==================================================
// Line timing, in dot clocks
`define H_ACTIVE_PIXELS      11'h140
`define H_SYNC_MIN           8'h03
`define H_BACK_PORCH_MIN     8'h03
`define H_FRONT_PORCH_MIN    8'h03

// ==================================================
// Frame timing, in lines
`define V_ACTIVE_LINES       11'h1E0
`define V_SYNC_MIN           8'h02
`define V_BACK_PORCH_MIN     8'h02
`define V_FRONT_PORCH_MIN    8'h02

// ==================================================
// Reset values
`define PIXEL_RESET          18'h00000
`define POS_RESET            11'h000

`endif

/* design/dot_clock_divider.v */
`timescale 1ns/1ps
`include "rgb_panel_consts.vh"

module dot_clock_divider (
   input  wire       ref_clk_i,
   input  wire       rst_i,
   output reg        pixel_clock_o,
   output wire       update_o
);

   reg  [2:0] phase;
   wire [2:0] next_phase;

   assign next_phase = phase + 3'h1;
   // Pulse in the last cycle before the falling edge: outputs change with it
   assign update_o   = (phase == `DOT_UPDATE_PHASE);

   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase         <= 3'h0;
         pixel_clock_o <= 1'b1;
      end else begin
         phase         <= next_phase;
         pixel_clock_o <= (next_phase < `DOT_HIGH_PHASES);
      end
   end

endmodule // dot_clock_divider

/* design/timing_counter.v */
`timescale 1ns/1ps
`include "rgb_panel_consts.vh"

module timing_counter (
   input  wire        ref_clk_i,
   input  wire        rst_i,
   input  wire        step_i,
   input  wire [7:0]  sync_len_i,
   input  wire [7:0]  back_len_i,
   input  wire [10:0] active_len_i,
   input  wire [7:0]  front_len_i,
   output wire        sync_o,
   output wire        active_o,
   output wire        last_o
);

   reg  [10:0] pos;
   wire [10:0] act_start;
   wire [10:0] act_end;
   wire [10:0] total;

   // ==================================================
   // Phase boundaries: sync, back porch, active, front porch
   assign act_start = {3'h0, sync_len_i} + {3'h0, back_len_i};
   assign act_end   = act_start + active_len_i;
   assign total     = act_end + {3'h0, front_len_i};

   assign sync_o    = (pos < {3'h0, sync_len_i});
   assign active_o  = (pos >= act_start) && (pos < act_end);
   assign last_o    = (pos >= total - 11'h001);

   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pos <= `POS_RESET;
      end else if (step_i) begin
         if (last_o) begin
            pos <= `POS_RESET;
         end else begin
            pos <= pos + 11'h001;
         end
      end
   end

endmodule // timing_counter

/* design/rgb_panel_frame_timing.v */
// How it works
// - Line sync held active at least 3 dot clocks each line.
// - At least 3 dot clocks of back porch after line sync.
// - Exactly 320 active pixel clocks per line, one pixel each.
// - At least 3 dot clocks of front porch before next line sync.
// - Frame sync held active at least 2 lines per frame.
// - At least 2 blank back porch lines after frame sync.
// - Exactly 480 active lines per frame.
// - At least 2 blank front porch lines before next frame sync.
// - Frame rate between 50 and 80 Hz, 60 Hz typical.
// - Dot clock between 10 and 15 MHz, 12.5 MHz typical.
// - Frame period is sync plus back porch, active and front porch lines.
// - Line period is sync plus back porch, active and front porch clocks.
// - Dot clock and line sync run continuously while pixels flow.
// - Pixel valid qualifies the RGB stream; the panel trusts it.
`timescale 1ns/1ps
`include "rgb_panel_consts.vh"

module rgb_panel_frame_timing (
   input  wire        ref_clk_i,
   input  wire        rst_i,
   input  wire [17:0] pixel_data_i,
   input  wire [7:0]  hsync_width_i,
   input  wire [7:0]  h_back_porch_i,
   input  wire [7:0]  h_front_porch_i,
   input  wire [7:0]  vsync_width_i,
   input  wire [7:0]  v_back_porch_i,
   input  wire [7:0]  v_front_porch_i,
   output wire        pixel_clock_o,
   output reg         hsync_n_o,
   output reg         vsync_n_o,
   output reg         pixel_valid_o,
   output reg  [17:0] pixel_data_o,
   output reg         pixel_take_o,
   output reg         frame_start_o
);

   wire       update;
   wire       h_sync;
   wire       h_active;
   wire       h_last;
   wire       v_sync;
   wire       v_active;
   wire       v_last;
   wire       v_step;
   wire       next_valid;
   wire [7:0] h_sync_len;
   wire [7:0] h_bp_len;
   wire [7:0] h_fp_len;
   wire [7:0] v_sync_len;
   wire [7:0] v_bp_len;
   wire [7:0] v_fp_len;
   reg        first_line;

   // ==================================================
   // Programmed lengths, clamped to the panel minimums
   assign h_sync_len = (hsync_width_i   < `H_SYNC_MIN)        ? `H_SYNC_MIN        : hsync_width_i;
   assign h_bp_len   = (h_back_porch_i  < `H_BACK_PORCH_MIN)  ? `H_BACK_PORCH_MIN  : h_back_porch_i;
   assign h_fp_len   = (h_front_porch_i < `H_FRONT_PORCH_MIN) ? `H_FRONT_PORCH_MIN : h_front_porch_i;
   assign v_sync_len = (vsync_width_i   < `V_SYNC_MIN)        ? `V_SYNC_MIN        : vsync_width_i;
   assign v_bp_len   = (v_back_porch_i  < `V_BACK_PORCH_MIN)  ? `V_BACK_PORCH_MIN  : v_back_porch_i;
   assign v_fp_len   = (v_front_porch_i < `V_FRONT_PORCH_MIN) ? `V_FRONT_PORCH_MIN : v_front_porch_i;
   // Lengths above the minimums trade frame rate against dot clock

   // ==================================================
   // Dot clock: free running divide by eight of the reference clock
   dot_clock_divider u_dot_clock (
      .ref_clk_i     (ref_clk_i),
      .rst_i         (rst_i),
      .pixel_clock_o (pixel_clock_o),
      .update_o      (update)
   );

   // ==================================================
   // Line counter, one step per dot clock
   timing_counter u_line_timing (
      .ref_clk_i    (ref_clk_i),
      .rst_i        (rst_i),
      .step_i       (update),
      .sync_len_i   (h_sync_len),
      .back_len_i   (h_bp_len),
      .active_len_i (`H_ACTIVE_PIXELS),
      .front_len_i  (h_fp_len),
      .sync_o       (h_sync),
      .active_o     (h_active),
      .last_o       (h_last)
   );

   // ==================================================
   // Frame counter, one step per line
   assign v_step = update & h_last;

   timing_counter u_frame_timing (
      .ref_clk_i    (ref_clk_i),
      .rst_i        (rst_i),
      .step_i       (v_step),
      .sync_len_i   (v_sync_len),
      .back_len_i   (v_bp_len),
      .active_len_i (`V_ACTIVE_LINES),
      .front_len_i  (v_fp_len),
      .sync_o       (v_sync),
      .active_o     (v_active),
      .last_o       (v_last)
   );

   // ==================================================
   // Output stage: all panel signals change with the dot clock fall
   assign next_valid = h_active & v_active;

   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hsync_n_o     <= 1'b1;
         vsync_n_o     <= 1'b1;
         pixel_valid_o <= 1'b0;
         pixel_data_o  <= `PIXEL_RESET;
         pixel_take_o  <= 1'b0;
         frame_start_o <= 1'b0;
         first_line    <= 1'b1;
      end else begin
         pixel_take_o  <= update & next_valid;
         frame_start_o <= update & first_line & v_sync & h_sync;
         if (update) begin
            hsync_n_o     <= ~h_sync;
            vsync_n_o     <= ~v_sync;
            pixel_valid_o <= next_valid;
            if (next_valid) begin
               pixel_data_o <= pixel_data_i;
            end else begin
               pixel_data_o <= `PIXEL_RESET;
            end
            first_line <= h_last & v_last;
         end
      end
   end

endmodule // rgb_panel_frame_timing

/* tb/panel_sva.sv */
`timescale 1ns/1ps
module panel_sva (
   input wire        ref_clk_i,
   input wire        rst_i,
   input wire [7:0]  hsync_width_i,
   input wire [7:0]  h_back_porch_i,
   input wire [7:0]  h_front_porch_i,
   input wire        pixel_clock_o,
   input wire        hsync_n_o,
   input wire        vsync_n_o,
   input wire        pixel_valid_o,
   input wire [17:0] pixel_data_o,
   input wire        pixel_take_o,
   input wire        frame_start_o
);
   reg [15:0] lo, hi, n;
   reg        seen;
   // ==========
   // Clamped length in reference cycles
   function [15:0] d(input [7:0] x);
      d = 16'h0008 * ((x < 8'h03) ? 8'h03 : x);
   endfunction
   always @(posedge ref_clk_i) begin
      lo <= hsync_n_o ? 16'h0000 : lo + 16'h0001;
      hi <= hsync_n_o ? hi + 16'h0001 : 16'h0000;
      n <= pixel_valid_o ? n + 16'h0001 : 16'h0000;
   end
   always @(posedge ref_clk_i or posedge rst_i)
      seen <= rst_i ? 1'b0 : (seen | !hsync_n_o);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   chk_sync_len: assert property ($rose(hsync_n_o) |-> lo == d(hsync_width_i)) else $error("sync");
   chk_back_len: assert property ($rose(pixel_valid_o) |-> hi == d(h_back_porch_i)) else $error("bp");
   chk_pixel_count: assert property ($fell(pixel_valid_o) |-> n == 16'h0A00) else $error("px");
   chk_line_len: assert property ($fell(hsync_n_o) && seen |->
      hi == d(h_back_porch_i) + 16'h0A00 + d(h_front_porch_i)) else $error("line");
   chk_idle_zero: assert property (!pixel_valid_o |-> pixel_data_o == 18'h00000) else $error("zero");
   chk_blank_quiet: assert property (!(hsync_n_o && vsync_n_o) |-> !pixel_valid_o) else $error("de");
   chk_vsync_align: assert property ($changed(vsync_n_o) |-> $fell(hsync_n_o)) else $error("vs");
   chk_dot_high: assert property ($rose(pixel_clock_o) |->
      pixel_clock_o[*4] ##1 !pixel_clock_o) else $error("dot");
   chk_frame_start: assert property (frame_start_o == $fell(vsync_n_o)) else $error("frame start");
   chk_take_pulse: assert property (pixel_take_o |-> pixel_valid_o && $fell(pixel_clock_o)) else $error("take");
   cover property ($rose(pixel_valid_o));
   cover property ($fell(vsync_n_o));
   cover property ($rose(hsync_n_o) && hsync_width_i == 8'h05);
endmodule // panel_sva
bind rgb_panel_frame_timing panel_sva i_sva (.ref_clk_i, .rst_i, .hsync_width_i, .h_back_porch_i,
   .h_front_porch_i, .pixel_clock_o, .hsync_n_o, .vsync_n_o, .pixel_valid_o, .pixel_data_o, .pixel_take_o,
   .frame_start_o);

/* tb/panel_model.sv */
`timescale 1ns/1ps
module panel_model (
   input wire        pixel_clock_i,
   input wire        pixel_valid_i,
   input wire [17:0] pixel_data_i,
   output reg [10:0] valid_dots_o = 11'h000,
   output reg [10:0] lines_o = 11'h000,
   output reg [17:0] first_pixel_o = 18'h00000
);
   reg [10:0] cnt = 11'h000;
   always @(posedge pixel_clock_i) begin
      if (pixel_valid_i) begin
         if (cnt == 11'h000) first_pixel_o <= pixel_data_i;
         cnt <= cnt + 11'h001;
      end else if (cnt != 11'h000) begin
         valid_dots_o <= cnt;
         cnt <= 11'h000;
         lines_o <= lines_o + 11'h001;
      end
   end
endmodule // panel_model

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic        ref_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [17:0] px_in = 18'h00000;
   logic [7:0]  hw = 8'h00, hb = 8'h00, hf = 8'h00, vw = 8'h00, vb = 8'h00, vf = 8'h00;
   wire         pclk, hs_n, vs_n, de, take;
   wire  [17:0] px, first_px;
   wire  [10:0] dots, lines;
   int          n_mismatch = 0;
   int          comparisons = 0;
   int          cycles = 0;
   rgb_panel_frame_timing i_dut (.ref_clk_i, .rst_i, .pixel_data_i(px_in), .hsync_width_i(hw),
      .h_back_porch_i(hb), .h_front_porch_i(hf), .vsync_width_i(vw), .v_back_porch_i(vb),
      .v_front_porch_i(vf), .pixel_clock_o(pclk), .hsync_n_o(hs_n), .vsync_n_o(vs_n),
      .pixel_valid_o(de), .pixel_data_o(px), .pixel_take_o(take), .frame_start_o());
   panel_model i_panel (.pixel_clock_i(pclk), .pixel_valid_i(de), .pixel_data_i(px),
      .valid_dots_o(dots), .lines_o(lines), .first_pixel_o(first_px));
   always #5 ref_clk_i = ~ref_clk_i;
   // ==========
   // Pixel source steps on each take; run ceiling
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      px_in <= rst_i ? 18'h00000 : px_in + {17'h00000, take};
      if (cycles == 60000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0d seen %0d", name, exp, seen);
      end
   endtask
   task automatic start(input logic [39:0] cfg);
      rst_i <= 1'b1;
      {hw, hb, hf, vw, vb} <= cfg;
      repeat (4) @(posedge ref_clk_i);
      rst_i <= 1'b0;
   endtask
   task automatic measure(input int vs_exp, input int lead_exp);
      int v;
      int t;
      logic [10:0] n0;
      v = 0;
      t = 0;
      while (vs_n !== 1'b0) @(posedge ref_clk_i);
      while (de !== 1'b1) begin
         v += (vs_n === 1'b0);
         t++;
         @(posedge ref_clk_i);
      end
      check("vsync_len", v, vs_exp);
      check("lead_len", t, lead_exp);
      n0 = lines;
      while (lines !== n0 + 11'h002) @(posedge ref_clk_i);
      check("valid_dots", dots, 320);
      check("first_pixel", first_px, 320);
   endtask
   task automatic test_min_lengths;
      start(40'h0000000000);
      measure(5264, 10576);
   endtask
   task automatic test_programmed;
      start(40'h0507090304);
      measure(8184, 19192);
   endtask
   task report_and_stop;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      test_min_lengths();
      test_programmed();
      report_and_stop();
   end
endmodule // tb_top
